// file: core/isvm_consts.svh
// Constants for the interrupt source and vector map: register offsets, field positions, trap numbers.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef ISVM_CONSTS_SVH
`define ISVM_CONSTS_SVH

`define ISVM_NUM_SRC 56
`define ISVM_NUM_TRAP 9
// Trap numbers of the source groups.
`define ISVM_TN_CC0 8'h10
`define ISVM_TN_CC16 8'h30
`define ISVM_TN_CC29 8'h44
`define ISVM_TN_T0 8'h20
`define ISVM_TN_T1 8'h21
`define ISVM_TN_T7 8'h3D
`define ISVM_TN_T8 8'h3E
`define ISVM_TN_GPT 8'h22
`define ISVM_TN_ADC 8'h28
`define ISVM_TN_ADE 8'h29
`define ISVM_TN_ASCT 8'h2A
`define ISVM_TN_ASCTB 8'h47
`define ISVM_TN_SSC 8'h2D
`define ISVM_TN_PWM 8'h3F
`define ISVM_TN_XP 8'h40
// Hardware trap numbers; class B sources share one number.
`define ISVM_TN_NMI 8'h02
`define ISVM_TN_STKOF 8'h04
`define ISVM_TN_STKUF 8'h06
`define ISVM_TN_CLASSB 8'h0A
// Source index boundaries.
`define ISVM_IDX_CC16 6'd16
`define ISVM_IDX_CC29 6'd29
`define ISVM_IDX_T0 6'd32
`define ISVM_IDX_GPT 6'd36
`define ISVM_IDX_ADC 6'd42
`define ISVM_IDX_ASC 6'd44
`define ISVM_IDX_SSC 6'd48
`define ISVM_IDX_PWM 6'd51
`define ISVM_IDX_XP 6'd52
// Wishbone register map, byte addresses.
`define ISVM_ADDR_CTRL_BASE 10'h000
`define ISVM_ADDR_TRAPFLAG 10'h100
`define ISVM_ADDR_STATUS 10'h104
`define ISVM_ADDR_MASK 10'h108
`define ISVM_ADDR_VECTOR 10'h10C
`define ISVM_ADDR_SERVICE 10'h110
// Control word layout: bits 1:0 group, 5:2 level, 6 enable, 7 request.
`define ISVM_F_GROUP_LEVEL_FIELD_LO 0
`define ISVM_F_PRIORITY_LEVEL_FIELD_LO 2
`define ISVM_F_IE 6
`define ISVM_F_IR 7
`define ISVM_RESET_CTRL 8'h00
`define ISVM_VEC_SHIFT 2
// Status bits of the block's own interrupt line.
`define ISVM_EV_ACCEPT 0
`define ISVM_EV_TRAP 1
`define ISVM_EV_WIDTH 2

`endif

// file: core/isvm_pkg.sv
// Types shared by the interrupt source and vector map.
// Assumes isvm_consts.svh is on the include path.
`include "isvm_consts.svh"
package isvm_pkg;
	typedef struct packed {
		logic valid;
		logic [7:0] trapNumber;
		logic [3:0] level;
		logic [1:0] group;
	} isvm_req_s;
	typedef struct packed {
		logic [31:0] dat;
		logic [9:0] adr;
		logic [3:0] sel;
		logic we;
		logic cyc;
		logic stb;
	} isvm_wbreq_s;
	typedef enum logic [1:0] {
		ISVM_IDLE = 2'b00,
		ISVM_INT_SVC = 2'b01,
		ISVM_TRAP_SVC = 2'b10
	} isvm_svc_e;
endpackage

// file: core/isvm_arbiter.sv
// Priority arbiter for the interrupt sources: highest level wins, then highest group, then lowest index.
// Assumes control words from the main module, same clock domain, purely combinational.
`timescale 1ns/1ps
`include "isvm_consts.svh"
module isvm_arbiter #(
	parameter int NUM_SRC = `ISVM_NUM_SRC
) (
	input wire logic [NUM_SRC-1:0][7:0] ctrlWord,
	output isvm_pkg::isvm_req_s winner,
	output logic [5:0] winnerIdx
);
	import isvm_pkg::*;

	// ----------------------------------------
	// Trap number of each source
	// ----------------------------------------
	function automatic logic [7:0] trapOf(input logic [5:0] idx);
		logic [7:0] t;
		t = 8'h00;
		if (idx < `ISVM_IDX_CC16) begin
			t = `ISVM_TN_CC0 + {2'b00, idx};
		end else if (idx < `ISVM_IDX_CC29) begin
			t = `ISVM_TN_CC16 + {2'b00, idx - `ISVM_IDX_CC16};
		end else if (idx < `ISVM_IDX_T0) begin
			t = `ISVM_TN_CC29 + {2'b00, idx - `ISVM_IDX_CC29};
		end else if (idx < `ISVM_IDX_GPT) begin
			unique case (idx - `ISVM_IDX_T0)
				6'd0: t = `ISVM_TN_T0;
				6'd1: t = `ISVM_TN_T1;
				6'd2: t = `ISVM_TN_T7;
				default: t = `ISVM_TN_T8;
			endcase
		end else if (idx < `ISVM_IDX_ADC) begin
			t = `ISVM_TN_GPT + {2'b00, idx - `ISVM_IDX_GPT};
		end else if (idx < `ISVM_IDX_ASC) begin
			t = (idx == `ISVM_IDX_ADC) ? `ISVM_TN_ADC : `ISVM_TN_ADE;
		end else if (idx < `ISVM_IDX_SSC) begin
			if (idx == `ISVM_IDX_SSC - 6'd1) begin
				t = `ISVM_TN_ASCTB;
			end else begin
				t = `ISVM_TN_ASCT + {2'b00, idx - `ISVM_IDX_ASC};
			end
		end else if (idx < `ISVM_IDX_PWM) begin
			t = `ISVM_TN_SSC + {2'b00, idx - `ISVM_IDX_SSC};
		end else if (idx == `ISVM_IDX_PWM) begin
			t = `ISVM_TN_PWM;
		end else begin
			t = `ISVM_TN_XP + {2'b00, idx - `ISVM_IDX_XP};
		end
		return t;
	endfunction

	// ----------------------------------------
	// Selection
	// ----------------------------------------
	always_comb begin
		logic [3:0] lvl;
		logic [1:0] grp;
		lvl = 4'h0;
		grp = 2'h0;
		winner = '0;
		winnerIdx = 6'd0;
		for (int i = 0; i < NUM_SRC; i++) begin
			lvl = ctrlWord[i][`ISVM_F_PRIORITY_LEVEL_FIELD_LO +: 4];
			grp = ctrlWord[i][`ISVM_F_GROUP_LEVEL_FIELD_LO +: 2];
			// Only pending and enabled sources compete.
			if (ctrlWord[i][`ISVM_F_IR] && ctrlWord[i][`ISVM_F_IE]) begin
				if (!winner.valid || lvl > winner.level ||
						(lvl == winner.level && grp > winner.group)) begin
					winner.valid = 1'b1;
					winner.level = lvl;
					winner.group = grp;
					winner.trapNumber = trapOf(6'(i));
					winnerIdx = 6'(i);
				end
			end
		end
	end
endmodule

// file: core/isvm_controller.sv
// Interrupt source and vector map: per-source control words, arbitration, hardware traps, vector to the CPU.
// Assumes one 250 MHz clock, synchronous peripheral pulses on the same clock, classic Wishbone slave.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`include "isvm_consts.svh"

module isvm_controller #(
	parameter int NUM_SRC = `ISVM_NUM_SRC,
	parameter int NUM_TRAP = `ISVM_NUM_TRAP
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [NUM_SRC-1:0] srcPulse,
	input wire logic [NUM_TRAP-1:0] trapPulse,
	input wire logic [3:0] cpuLevel,
	input wire logic cpuTake,
	input wire logic cpuReturn,
	input wire logic [31:0] wb_dat_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic svcRequest,
	output logic svcIsTrap,
	output logic [7:0] svcTrapNumber,
	output logic [23:0] svcVector,
	output logic irq
);
	import isvm_pkg::*;

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [NUM_SRC-1:0][7:0] ctrlWord, next_ctrlWord;
	logic [NUM_TRAP-1:0] trapFlag, next_trapFlag;
	logic [`ISVM_EV_WIDTH-1:0] evStatus, next_evStatus;
	logic [`ISVM_EV_WIDTH-1:0] evMask, next_evMask;
	isvm_svc_e svcState, next_svcState;
	logic [1:0] trapClass, next_trapClass;
	// Source behind the standing offer, so that a take clears that flag even if a new winner appeared meanwhile.
	logic [5:0] svcIdx, next_svcIdx;
	logic [31:0] next_wbDat;
	logic next_wbAck;
	logic next_svcRequest, next_svcIsTrap, next_irq;
	logic [7:0] next_svcTrapNumber;
	logic [23:0] next_svcVector;

	isvm_req_s winner;
	logic [5:0] winnerIdx;

	isvm_arbiter #(
		.NUM_SRC(NUM_SRC)
	) u_arbiter (
		.ctrlWord(ctrlWord),
		.winner(winner),
		.winnerIdx(winnerIdx)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [23:0] vectorOf(input logic [7:0] tn);
		return {14'h0000, tn, 2'b00};
	endfunction

	// Trap class: 2 for the class A traps (bits 0-2), 1 for class B, 0 for none.
	function automatic logic [1:0] classOf(input logic [NUM_TRAP-1:0] f);
		logic [1:0] c;
		c = 2'd0;
		if (|f[2:0]) begin
			c = 2'd2;
		end else if (|f[NUM_TRAP-1:3]) begin
			c = 2'd1;
		end
		return c;
	endfunction

	function automatic logic [7:0] trapNumOf(input logic [NUM_TRAP-1:0] f);
		logic [7:0] t;
		t = `ISVM_TN_CLASSB;
		if (f[0]) begin
			t = `ISVM_TN_NMI;
		end else if (f[1]) begin
			t = `ISVM_TN_STKOF;
		end else if (f[2]) begin
			t = `ISVM_TN_STKUF;
		end
		return t;
	endfunction

	function automatic logic [31:0] laneWrite(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = d[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		logic access;
		logic [31:0] wrVal;
		logic [5:0] srcIdx;
		logic pendTrap;
		logic [1:0] pendClass;
		logic evAccept, evTrap;
		next_ctrlWord = ctrlWord;
		next_trapFlag = trapFlag;
		next_evStatus = evStatus;
		next_evMask = evMask;
		next_svcState = svcState;
		next_trapClass = trapClass;
		next_wbDat = 32'h0000_0000;
		next_wbAck = 1'b0;
		next_svcRequest = svcRequest;
		next_svcIsTrap = svcIsTrap;
		next_svcTrapNumber = svcTrapNumber;
		next_svcVector = svcVector;
		access = wb_cyc_i && wb_stb_i && !wb_ack_o;
		wrVal = 32'h0000_0000;
		srcIdx = wb_adr_i[7:2];
		evAccept = 1'b0;
		evTrap = 1'b0;
		next_svcIdx = svcIdx;
		pendTrap = |trapFlag;
		pendClass = classOf(trapFlag);

		// Bus writes first, so hardware events below win over a software clear.
		if (access) begin
			next_wbAck = 1'b1;
			if (wb_adr_i < `ISVM_ADDR_TRAPFLAG && wb_adr_i[9:8] == 2'b00 &&
					{2'b00, srcIdx} < 8'(NUM_SRC)) begin
				wrVal = laneWrite({24'h000000, ctrlWord[srcIdx]}, wb_dat_i, wb_sel_i);
				if (wb_we_i) begin
					next_ctrlWord[srcIdx] = wrVal[7:0];
				end else begin
					next_wbDat = {24'h000000, ctrlWord[srcIdx]};
				end
			end else if (wb_adr_i == `ISVM_ADDR_TRAPFLAG) begin
				wrVal = laneWrite(32'(trapFlag), wb_dat_i, wb_sel_i);
				if (wb_we_i) begin
					next_trapFlag = wrVal[NUM_TRAP-1:0];
				end else begin
					next_wbDat = 32'(trapFlag);
				end
			end else if (wb_adr_i == `ISVM_ADDR_STATUS) begin
				if (!wb_we_i) begin
					next_wbDat = 32'(evStatus);
					next_evStatus = '0;
				end
			end else if (wb_adr_i == `ISVM_ADDR_MASK) begin
				wrVal = laneWrite(32'(evMask), wb_dat_i, wb_sel_i);
				if (wb_we_i) begin
					next_evMask = wrVal[`ISVM_EV_WIDTH-1:0];
				end else begin
					next_wbDat = 32'(evMask);
				end
			end else if (wb_adr_i == `ISVM_ADDR_VECTOR) begin
				next_wbDat = {svcIsTrap, svcRequest, 6'h00, svcVector};
			end else if (wb_adr_i == `ISVM_ADDR_SERVICE) begin
				next_wbDat = {28'h0000000, trapClass, svcState};
			end
		end

		// Peripheral events set request flags regardless of the enable bit.
		for (int i = 0; i < NUM_SRC; i++) begin
			if (srcPulse[i]) begin
				next_ctrlWord[i][`ISVM_F_IR] = 1'b1;
			end
		end
		next_trapFlag = next_trapFlag | trapPulse;

		// Service offer: traps ignore all enables and the CPU level.
		if (pendTrap && (svcState != ISVM_TRAP_SVC || pendClass > trapClass)) begin
			next_svcRequest = 1'b1;
			next_svcIsTrap = 1'b1;
			next_svcTrapNumber = trapNumOf(trapFlag);
			next_svcVector = vectorOf(trapNumOf(trapFlag));
		end else if (winner.valid && svcState != ISVM_TRAP_SVC &&
				winner.level > cpuLevel) begin
			next_svcRequest = 1'b1;
			next_svcIsTrap = 1'b0;
			next_svcTrapNumber = winner.trapNumber;
			next_svcVector = vectorOf(winner.trapNumber);
			next_svcIdx = winnerIdx;
		end else begin
			next_svcRequest = 1'b0;
			next_svcIsTrap = 1'b0;
		end

		// The CPU takes the offer standing this cycle.
		if (cpuTake && svcRequest) begin
			evAccept = 1'b1;
			if (svcIsTrap) begin
				next_svcState = ISVM_TRAP_SVC;
				// The class comes from the offer taken, not from flags that may have grown since.
				next_trapClass = (svcTrapNumber == `ISVM_TN_CLASSB) ? 2'd1 : 2'd2;
				evTrap = 1'b1;
			end else begin
				next_svcState = ISVM_INT_SVC;
				next_ctrlWord[svcIdx][`ISVM_F_IR] = srcPulse[svcIdx];
			end
			next_svcRequest = 1'b0;
		end else if (cpuReturn) begin
			// Nesting depth is not tracked; the CPU restores its own context.
			next_svcState = ISVM_IDLE;
			next_trapClass = 2'd0;
		end

		next_evStatus[`ISVM_EV_ACCEPT] = next_evStatus[`ISVM_EV_ACCEPT] | evAccept;
		next_evStatus[`ISVM_EV_TRAP] = next_evStatus[`ISVM_EV_TRAP] | evTrap;
		next_irq = |(next_evStatus & next_evMask);
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < NUM_SRC; i++) begin
				ctrlWord[i] <= `ISVM_RESET_CTRL;
			end
			trapFlag <= '0;
			evStatus <= '0;
			evMask <= '0;
			svcState <= ISVM_IDLE;
			trapClass <= 2'd0;
			svcIdx <= 6'd0;
			wb_dat_o <= 32'h0000_0000;
			wb_ack_o <= 1'b0;
			svcRequest <= 1'b0;
			svcIsTrap <= 1'b0;
			svcTrapNumber <= 8'h00;
			svcVector <= 24'h000000;
			irq <= 1'b0;
		end else begin
			ctrlWord <= next_ctrlWord;
			trapFlag <= next_trapFlag;
			evStatus <= next_evStatus;
			evMask <= next_evMask;
			svcState <= next_svcState;
			trapClass <= next_trapClass;
			svcIdx <= next_svcIdx;
			wb_dat_o <= next_wbDat;
			wb_ack_o <= next_wbAck;
			svcRequest <= next_svcRequest;
			svcIsTrap <= next_svcIsTrap;
			svcTrapNumber <= next_svcTrapNumber;
			svcVector <= next_svcVector;
			irq <= next_irq;
		end
	end
endmodule

// file: bench/isvm_controller_asserts.sv
// Concurrent checks on the ports of the interrupt source and vector map.
// Assumes one clock and a synchronous active-low reset shared by every port.
`timescale 1ns/1ps
module isvm_controller_asserts #(
	parameter int NUM_SRC = 56,
	parameter int NUM_TRAP = 9
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [NUM_SRC-1:0] srcPulse,
	input wire logic [NUM_TRAP-1:0] trapPulse,
	input wire logic [3:0] cpuLevel,
	input wire logic cpuTake,
	input wire logic cpuReturn,
	input wire logic [31:0] wb_dat_i,
	input wire logic [9:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic svcRequest,
	input wire logic svcIsTrap,
	input wire logic [7:0] svcTrapNumber,
	input wire logic [23:0] svcVector,
	input wire logic irq
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Tracks whether the CPU is inside a trap service, seen from the handshake alone; a take wins over a return.
	// A class A service blocks every offer, a class B service blocks interrupts and further class B traps.
	logic trapSvc;
	logic trapSvcA;
	logic next_trapSvc;
	logic next_trapSvcA;
	always_comb begin
		next_trapSvc = trapSvc;
		next_trapSvcA = trapSvcA;
		if (cpuTake && svcRequest) begin
			next_trapSvc = svcIsTrap;
			next_trapSvcA = svcIsTrap && svcTrapNumber != 8'h0A;
		end else if (cpuReturn) begin
			next_trapSvc = 1'b0;
			next_trapSvcA = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			trapSvc <= 1'b0;
			trapSvcA <= 1'b0;
		end else begin
			trapSvc <= next_trapSvc;
			trapSvcA <= next_trapSvcA;
		end
	end
	sequence s_nmiRaise;
		trapPulse[0] && !trapSvcA && !cpuTake ##1 !cpuTake;
	endsequence
	sequence s_nmiOffer;
		svcRequest && svcIsTrap && svcTrapNumber == 8'h02;
	endsequence
	property p_ackNext;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ackNext: assert property (p_ackNext) else $error("ack missing one cycle after request");
	property p_ackOne;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack longer than one cycle");
	property p_datIdle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data not zero outside ack");
	property p_vector;
		svcRequest |-> svcVector == {14'h0, svcTrapNumber, 2'b00};
	endproperty
	a_vector: assert property (p_vector) else $error("vector is not trap number times four");
	property p_trapNum;
		svcRequest && svcIsTrap |-> svcTrapNumber inside {8'h02, 8'h04, 8'h06, 8'h0A};
	endproperty
	a_trapNum: assert property (p_trapNum) else $error("trap offer with a foreign number");
	property p_srcNum;
		svcRequest && !svcIsTrap |-> svcTrapNumber inside {[8'h10:8'h47]};
	endproperty
	a_srcNum: assert property (p_srcNum) else $error("source offer outside the source range");
	property p_trapFirst;
		trapSvc && svcRequest |-> svcIsTrap;
	endproperty
	a_trapFirst: assert property (p_trapFirst) else $error("interrupt offered during trap service");
	property p_nmiTake;
		trapSvcA |-> !svcRequest;
	endproperty
	a_nmiTake: assert property (p_nmiTake) else $error("offer during class A trap service");
	property p_nmi;
		s_nmiRaise |=> s_nmiOffer;
	endproperty
	a_nmi: assert property (p_nmi) else $error("top trap not offered two cycles after pulse");
endmodule

// file: bench/isvm_cpu_model.sv
// Behavioural CPU side: takes standing offers when allowed and returns after a fixed service time.
// Assumes the controller's clock and reset; the bench gates taking and returning.
`timescale 1ns/1ps
module isvm_cpu_model #(
	parameter int SVC_CYCLES = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic svcRequest,
	input wire logic takeEn,
	input wire logic retEn,
	output logic cpuTake,
	output logic cpuReturn,
	output logic inSvc
);
	int cnt;
	always_ff @(posedge sys_clk) begin
		cpuTake <= 1'b0;
		cpuReturn <= 1'b0;
		if (!rst_n) begin
			inSvc <= 1'b0;
			cnt <= 0;
		end else if (cpuTake) begin
			inSvc <= 1'b1;
			cnt <= 0;
		end else if (svcRequest && takeEn) begin
			cpuTake <= 1'b1;
		end else if (inSvc && retEn) begin
			cnt <= cnt + 1;
			if (cnt == SVC_CYCLES - 1) begin
				cpuReturn <= 1'b1;
				inSvc <= 1'b0;
			end
		end
	end
endmodule

// file: bench/tb_isvm_controller.sv
// Self-checking bench: Wishbone register access, source mapping, arbitration, traps, status line.
// Assumes the controller, its package and the CPU model are compiled first.
`timescale 1ns/1ps
module tb_isvm_controller;
	localparam int NUM_SRC = 56;
	localparam int NUM_TRAP = 9;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [55:0] srcPulse = 56'h0;
	logic [8:0] trapPulse = 9'h000;
	logic [3:0] cpuLevel = 4'h0;
	logic [31:0] wbDatI = 32'h0;
	logic [9:0] wbAdr = 10'h000;
	logic wbWe = 1'b0;
	logic wbCyc = 1'b0;
	logic wbStb = 1'b0;
	logic takeEn = 1'b0;
	logic retEn = 1'b1;
	logic [31:0] wbDatO, q;
	logic wbAck, svcRequest, svcIsTrap, irq, cpuTake, cpuReturn, inSvc;
	logic [7:0] svcTrapNumber;
	logic [23:0] svcVector;
	int err_count = 0;
	int check_count = 0;
	always #2 sys_clk = ~sys_clk;
	isvm_controller #(.NUM_SRC(NUM_SRC), .NUM_TRAP(NUM_TRAP)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
		.srcPulse(srcPulse), .trapPulse(trapPulse), .cpuLevel(cpuLevel), .cpuTake(cpuTake),
		.cpuReturn(cpuReturn), .wb_dat_i(wbDatI), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_we_i(wbWe),
		.wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .svcRequest(svcRequest),
		.svcIsTrap(svcIsTrap), .svcTrapNumber(svcTrapNumber), .svcVector(svcVector), .irq(irq));
	isvm_cpu_model cpu (.sys_clk(sys_clk), .rst_n(rst_n), .svcRequest(svcRequest), .takeEn(takeEn),
		.retEn(retEn), .cpuTake(cpuTake), .cpuReturn(cpuReturn), .inSvc(inSvc));
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic results();
		$display("Errors %0d of %0d checks", err_count, check_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tmo(input int n);
		if (n >= 40) begin
			err_count++;
			$display("CHECK FAILED timeout expected 1 seen 0");
			results();
		end
	endtask
	task automatic waitV(ref logic s, input logic v);
		int n = 0;
		while (s !== v && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		tmo(n);
	endtask
	task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
		int n = 0;
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= w;
		wbAdr <= a;
		wbDatI <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (wbAck !== 1'b1 && n < 40);
		tmo(n);
		q = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic pulse(input logic [55:0] m, input logic [8:0] t);
		srcPulse <= m;
		trapPulse <= t;
		@(posedge sys_clk);
		srcPulse <= 56'h0;
		trapPulse <= 9'h000;
	endtask
	// Waits for the take pulse itself, since the CPU may already be in a service when a trap nests.
	task automatic take();
		takeEn <= 1'b1;
		waitV(cpuTake, 1'b1);
		takeEn <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic arb(input int i, input int j, input logic [31:0] ci, input logic [31:0] cj, input logic [7:0] e);
		wb(1'b1, 10'(4 * i), ci);
		wb(1'b1, 10'(4 * j), cj);
		pulse((56'h1 << i) | (56'h1 << j), 9'h000);
		waitV(svcRequest, 1'b1);
		check("winner", svcTrapNumber, e);
		take();
		waitV(inSvc, 1'b0);
		wb(1'b1, 10'(4 * i), 32'h0);
		wb(1'b1, 10'(4 * j), 32'h0);
	endtask
	function automatic logic [7:0] expNum(input int i);
		if (i < 16) return 8'h10 + 8'(i);
		if (i < 29) return 8'h30 + 8'(i - 16);
		if (i < 32) return 8'h44 + 8'(i - 29);
		if (i < 34) return 8'h20 + 8'(i - 32);
		if (i < 36) return 8'h3D + 8'(i - 34);
		if (i < 42) return 8'h22 + 8'(i - 36);
		if (i < 47) return 8'h28 + 8'(i - 42);
		if (i == 47) return 8'h47;
		if (i < 51) return 8'h2D + 8'(i - 48);
		if (i == 51) return 8'h3F;
		return 8'h40 + 8'(i - 52);
	endfunction
	// ------------------------------
	// Sequence
	// ------------------------------
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		wb(1'b0, 10'h000, 32'h0);
		check("ctrl reset", q, 32'h0);
		wb(1'b0, 10'h3FC, 32'h0);
		check("unmapped", q, 32'h0);
		for (int i = 0; i < NUM_SRC; i++) begin
			wb(1'b1, 10'(4 * i), 32'h44);
			pulse(56'h1 << i, 9'h000);
			waitV(svcRequest, 1'b1);
			check("number", svcTrapNumber, expNum(i));
			check("vector", svcVector, {14'h0, expNum(i), 2'b00});
			take();
			waitV(inSvc, 1'b0);
			wb(1'b1, 10'(4 * i), 32'h0);
		end
		wb(1'b1, 10'h004, 32'h04);
		pulse(56'h2, 9'h000);
		repeat (4) @(posedge sys_clk);
		check("disabled", 32'(svcRequest), 32'h0);
		wb(1'b0, 10'h004, 32'h0);
		check("pending", q, 32'h84);
		wb(1'b1, 10'h004, 32'hC4);
		waitV(svcRequest, 1'b1);
		check("enabled", svcTrapNumber, 8'h11);
		take();
		waitV(inSvc, 1'b0);
		arb(2, 5, 32'h4C, 32'h54, 8'h15);
		arb(6, 7, 32'h49, 32'h4A, 8'h17);
		cpuLevel <= 4'h5;
		wb(1'b1, 10'h00C, 32'h54);
		pulse(56'h8, 9'h000);
		repeat (4) @(posedge sys_clk);
		check("level held", 32'(svcRequest), 32'h0);
		cpuLevel <= 4'h4;
		waitV(svcRequest, 1'b1);
		check("level passed", svcTrapNumber, 8'h13);
		take();
		waitV(inSvc, 1'b0);
		cpuLevel <= 4'h0;
		wb(1'b1, 10'h00C, 32'h0);
		retEn <= 1'b0;
		pulse(56'h0, 9'h008);
		waitV(svcRequest, 1'b1);
		check("class B trap", 32'(svcIsTrap), 32'h1);
		check("class B vector", svcVector, 24'h000028);
		wb(1'b0, 10'h100, 32'h0);
		check("flags", q, 32'h8);
		take();
		wb(1'b1, 10'h000, 32'h7C);
		pulse(56'h1, 9'h000);
		repeat (4) @(posedge sys_clk);
		check("held off", 32'(svcRequest), 32'h0);
		pulse(56'h0, 9'h001);
		waitV(svcRequest, 1'b1);
		check("NMI number", svcTrapNumber, 8'h02);
		wb(1'b0, 10'h100, 32'h0);
		check("flags", q, 32'h9);
		take();
		wb(1'b1, 10'h100, 32'h0);
		retEn <= 1'b1;
		waitV(svcRequest, 1'b1);
		check("resumed", svcTrapNumber, 8'h10);
		take();
		waitV(inSvc, 1'b0);
		check("irq masked", 32'(irq), 32'h0);
		wb(1'b1, 10'h108, 32'h3);
		waitV(irq, 1'b1);
		wb(1'b0, 10'h104, 32'h0);
		check("status", q, 32'h3);
		wb(1'b0, 10'h104, 32'h0);
		check("status cleared", q, 32'h0);
		check("irq cleared", 32'(irq), 32'h0);
		results();
	end
endmodule
bind isvm_controller isvm_controller_asserts #(.NUM_SRC(NUM_SRC), .NUM_TRAP(NUM_TRAP)) chk (.sys_clk(sys_clk),
	.rst_n(rst_n), .srcPulse(srcPulse), .trapPulse(trapPulse), .cpuLevel(cpuLevel), .cpuTake(cpuTake),
	.cpuReturn(cpuReturn), .wb_dat_i(wb_dat_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .svcRequest(svcRequest),
	.svcIsTrap(svcIsTrap), .svcTrapNumber(svcTrapNumber), .svcVector(svcVector), .irq(irq));
